// >>> design/ea_pkg.sv
/*
 Package for the effective-address generator: address width, addressing-mode
 enumeration, opcode field positions and the opcode-column decode constants.
 Assumes the usual 8-bit core opcode map, with the addressing mode in the
 high opcode nibble.
*/
package ea_pkg;

   localparam int ADDR_WIDTH = 13;
   localparam int DIRECT_PAGE_WIDTH = 8;

   typedef enum logic [3:0]
   {
      mode_inherent = 4'h0,
      mode_immediate = 4'h1,
      mode_direct = 4'h2,
      mode_extended = 4'h3,
      mode_relative = 4'h4,
      mode_indexed_0 = 4'h5,
      mode_indexed_8 = 4'h6,
      mode_indexed_16 = 4'h7,
      mode_bit_set_clear = 4'h8,
      mode_bit_test_branch = 4'h9
   } mode_type;

   // Opcode fields
   localparam int COLUMN_MSB = 7;
   localparam int COLUMN_LSB = 4;
   localparam int BIT_NUM_MSB = 3;
   localparam int BIT_NUM_LSB = 1;
   localparam int SENSE_BIT = 0;
   localparam int LOW_NIBBLE_MSB = 3;
   localparam int LOW_NIBBLE_LSB = 0;

   // High-nibble columns of the opcode map
   localparam logic [3:0] COL_BIT_TEST = 4'h0;
   localparam logic [3:0] COL_BIT_SET_CLEAR = 4'h1;
   localparam logic [3:0] COL_BRANCH = 4'h2;
   localparam logic [3:0] COL_RMW_DIRECT = 4'h3;
   localparam logic [3:0] COL_RMW_INDEXED_8 = 4'h6;
   localparam logic [3:0] COL_RMW_INDEXED_0 = 4'h7;
   localparam logic [3:0] COL_IMMEDIATE = 4'ha;
   localparam logic [3:0] COL_DIRECT = 4'hb;
   localparam logic [3:0] COL_EXTENDED = 4'hc;
   localparam logic [3:0] COL_INDEXED_16 = 4'hd;
   localparam logic [3:0] COL_INDEXED_8 = 4'he;
   localparam logic [3:0] COL_INDEXED_0 = 4'hf;

   // Branch to subroutine sits in the immediate column but is relative
   localparam logic [3:0] LOW_BSR = 4'hd;

   // Branch condition selectors (low nibble of column 2)
   localparam logic [3:0] COND_BRA = 4'h0;
   localparam logic [3:0] COND_BRN = 4'h1;
   localparam logic [3:0] COND_BHI = 4'h2;
   localparam logic [3:0] COND_BLS = 4'h3;
   localparam logic [3:0] COND_BCC = 4'h4;
   localparam logic [3:0] COND_BCS = 4'h5;
   localparam logic [3:0] COND_BNE = 4'h6;
   localparam logic [3:0] COND_BEQ = 4'h7;
   localparam logic [3:0] COND_BHCC = 4'h8;
   localparam logic [3:0] COND_BHCS = 4'h9;
   localparam logic [3:0] COND_BPL = 4'ha;
   localparam logic [3:0] COND_BMI = 4'hb;
   localparam logic [3:0] COND_BMC = 4'hc;
   localparam logic [3:0] COND_BMS = 4'hd;
   localparam logic [3:0] COND_BIL = 4'he;
   localparam logic [3:0] COND_BIH = 4'hf;

   // Flag positions in condition_flags (H I N Z C)
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_I = 3;
   localparam int FLAG_H = 4;
   localparam int FLAGS_WIDTH = 5;

   // Instruction lengths in bytes
   localparam logic [1:0] LEN_ONE = 2'h1;
   localparam logic [1:0] LEN_TWO = 2'h2;
   localparam logic [1:0] LEN_THREE = 2'h3;

endpackage

// >>> design/branch_condition.sv
/*
 Branch condition evaluator: given the low opcode nibble, the condition flags
 and the interrupt line level, says whether a relative branch is taken.
 Assumes irq_line_high is already synchronised by the caller.
*/
`timescale 1ns/10ps
module branch_condition
(
   input  wire logic [3:0]                     selector,
   input  wire logic [ea_pkg::FLAGS_WIDTH-1:0] flags,
   input  wire logic                           irq_line_high,
   output logic                                taken
);

   logic c;
   logic z;
   logic n;
   logic i;
   logic h;

   assign c = flags[ea_pkg::FLAG_C];
   assign z = flags[ea_pkg::FLAG_Z];
   assign n = flags[ea_pkg::FLAG_N];
   assign i = flags[ea_pkg::FLAG_I];
   assign h = flags[ea_pkg::FLAG_H];

   // Pairs of conditions differ only in the sense of the selector's low bit
   always_comb
   begin
      case (selector)
         ea_pkg::COND_BRA:  taken = 1'b1;
         ea_pkg::COND_BRN:  taken = 1'b0;
         ea_pkg::COND_BHI:  taken = !(c | z);
         ea_pkg::COND_BLS:  taken = c | z;
         ea_pkg::COND_BCC:  taken = !c;
         ea_pkg::COND_BCS:  taken = c;
         ea_pkg::COND_BNE:  taken = !z;
         ea_pkg::COND_BEQ:  taken = z;
         ea_pkg::COND_BHCC: taken = !h;
         ea_pkg::COND_BHCS: taken = h;
         ea_pkg::COND_BPL:  taken = !n;
         ea_pkg::COND_BMI:  taken = n;
         ea_pkg::COND_BMC:  taken = !i;
         ea_pkg::COND_BMS:  taken = i;
         ea_pkg::COND_BIL:  taken = !irq_line_high;
         default:           taken = irq_line_high;
      endcase
   end

endmodule

// >>> design/cpu_effective_address_generator.sv
/*
 Effective-address generator of the CPU core. Takes the opcode and the two
 following instruction bytes, the index register, the program counter and
 the condition flags; decodes the addressing mode and registers the effective
 address, operand, branch target, next program counter and bit controls.
 Assumes the fetch unit presents all bytes of an instruction together with a
 one-cycle decode_valid, and that the data path returns the addressed byte
 (tested_byte) for bit-test instructions in the same cycle.
*/
`timescale 1ns/10ps
module cpu_effective_address_generator
(
   input  wire logic                           clk,
   input  wire logic                           reset_n,
   input  wire logic                           decode_valid,
   input  wire logic [7:0]                     opcode,
   input  wire logic [7:0]                     byte_two,
   input  wire logic [7:0]                     byte_three,
   input  wire logic [7:0]                     index_register,
   input  wire logic [ea_pkg::ADDR_WIDTH-1:0]  program_counter,
   input  wire logic [ea_pkg::FLAGS_WIDTH-1:0] condition_flags,
   input  wire logic                           irq_pin_n,
   input  wire logic [7:0]                     tested_byte,
   output logic                                result_valid,
   output ea_pkg::mode_type                    mode,
   output logic [1:0]                          instruction_length,
   output logic [ea_pkg::ADDR_WIDTH-1:0]       effective_address,
   output logic                                address_used,
   output logic [7:0]                          operand,
   output logic                                operand_immediate,
   output logic [ea_pkg::ADDR_WIDTH-1:0]       next_program_counter,
   output logic                                branch_taken,
   output logic [2:0]                          bit_number,
   output logic [7:0]                          bit_mask,
   output logic                                bit_set_value,
   output logic                                carry_update,
   output logic                                carry_value
);

   localparam int AW = ea_pkg::ADDR_WIDTH;

   // Synchroniser for the interrupt pin level tested by the line branches
   logic irq_meta;
   logic irq_sync;
   logic next_irq_meta;
   logic next_irq_sync;

   always_comb
   begin
      next_irq_meta = irq_pin_n;
      next_irq_sync = irq_meta;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         irq_meta <= 1'b1;
         irq_sync <= 1'b1;
      end
      else
      begin
         irq_meta <= next_irq_meta;
         irq_sync <= next_irq_sync;
      end
   end

   // Mode decode from the opcode column
   logic [3:0]       column;
   logic [3:0]       low_nibble;
   ea_pkg::mode_type decoded_mode;
   logic [1:0]       decoded_length;

   assign column = opcode[ea_pkg::COLUMN_MSB:ea_pkg::COLUMN_LSB];
   assign low_nibble = opcode[ea_pkg::LOW_NIBBLE_MSB:ea_pkg::LOW_NIBBLE_LSB];

   // Each column maps to one of the ten modes, except column a: BSR decodes as relative, the rest as immediate
   always_comb
   begin
      decoded_mode = ea_pkg::mode_inherent;
      if (column == ea_pkg::COL_BIT_TEST)
         decoded_mode = ea_pkg::mode_bit_test_branch;
      else if (column == ea_pkg::COL_BIT_SET_CLEAR)
         decoded_mode = ea_pkg::mode_bit_set_clear;
      else if (column == ea_pkg::COL_BRANCH)
         decoded_mode = ea_pkg::mode_relative;
      else if (column == ea_pkg::COL_RMW_DIRECT || column == ea_pkg::COL_DIRECT)
         decoded_mode = ea_pkg::mode_direct;
      else if (column == ea_pkg::COL_RMW_INDEXED_8 || column == ea_pkg::COL_INDEXED_8)
         decoded_mode = ea_pkg::mode_indexed_8;
      else if (column == ea_pkg::COL_RMW_INDEXED_0 || column == ea_pkg::COL_INDEXED_0)
         decoded_mode = ea_pkg::mode_indexed_0;
      else if (column == ea_pkg::COL_IMMEDIATE && low_nibble == ea_pkg::LOW_BSR)
         decoded_mode = ea_pkg::mode_relative;
      else if (column == ea_pkg::COL_IMMEDIATE)
         decoded_mode = ea_pkg::mode_immediate;
      else if (column == ea_pkg::COL_EXTENDED)
         decoded_mode = ea_pkg::mode_extended;
      else if (column == ea_pkg::COL_INDEXED_16)
         decoded_mode = ea_pkg::mode_indexed_16;
   end

   // Instruction length follows the mode
   always_comb
   begin
      case (decoded_mode)
         ea_pkg::mode_inherent:        decoded_length = ea_pkg::LEN_ONE;
         ea_pkg::mode_indexed_0:       decoded_length = ea_pkg::LEN_ONE;
         ea_pkg::mode_immediate:       decoded_length = ea_pkg::LEN_TWO;
         ea_pkg::mode_direct:          decoded_length = ea_pkg::LEN_TWO;
         ea_pkg::mode_relative:        decoded_length = ea_pkg::LEN_TWO;
         ea_pkg::mode_indexed_8:       decoded_length = ea_pkg::LEN_TWO;
         ea_pkg::mode_bit_set_clear:   decoded_length = ea_pkg::LEN_TWO;
         ea_pkg::mode_extended:        decoded_length = ea_pkg::LEN_THREE;
         ea_pkg::mode_indexed_16:      decoded_length = ea_pkg::LEN_THREE;
         ea_pkg::mode_bit_test_branch: decoded_length = ea_pkg::LEN_THREE;
         default:                      decoded_length = ea_pkg::LEN_ONE;
      endcase
   end

   // Branch condition for the relative column
   logic cond_taken;

   branch_condition condition_unit
   (
      .selector      (low_nibble),
      .flags         (condition_flags),
      .irq_line_high (irq_sync),
      .taken         (cond_taken)
   );

   // Address arithmetic; 13-bit sums wrap because upper bits are cut off
   logic [AW-1:0] fall_through;
   logic [7:0]    offset_byte;
   logic [AW-1:0] offset_extended;
   logic [AW-1:0] branch_target;
   logic [AW-1:0] index_wide;
   logic [15:0]   long_address;
   logic [15:0]   long_indexed;
   logic [8:0]    short_indexed;
   logic          tested_bit;
   logic          bit_match;

   always_comb
   begin
      fall_through = program_counter + {{(AW-2){1'b0}}, decoded_length};
      // The offset is always the last byte of the instruction
      offset_byte = (decoded_mode == ea_pkg::mode_bit_test_branch) ? byte_three : byte_two;
      offset_extended = {{(AW-8){offset_byte[7]}}, offset_byte};
      branch_target = fall_through + offset_extended;
      index_wide = {{(AW-8){1'b0}}, index_register};
      long_address = {byte_two, byte_three};
      long_indexed = long_address + {8'h00, index_register};
      short_indexed = {1'b0, byte_two} + {1'b0, index_register};
      tested_bit = tested_byte[opcode[ea_pkg::BIT_NUM_MSB:ea_pkg::BIT_NUM_LSB]];
      bit_match = (tested_bit == !opcode[ea_pkg::SENSE_BIT]);
   end

   // Registered results
   ea_pkg::mode_type mode_q;
   logic             valid_q;
   logic [1:0]       length_q;
   logic [AW-1:0]    ea_q;
   logic             used_q;
   logic [7:0]       operand_q;
   logic             imm_q;
   logic [AW-1:0]    npc_q;
   logic             taken_q;
   logic [2:0]       bitnum_q;
   logic             setval_q;
   logic             cupd_q;
   logic             cval_q;

   ea_pkg::mode_type next_mode;
   logic             next_valid;
   logic [1:0]       next_length;
   logic [AW-1:0]    next_ea;
   logic             next_used;
   logic [7:0]       next_operand;
   logic             next_imm;
   logic [AW-1:0]    next_npc;
   logic             next_taken;
   logic [2:0]       next_bitnum;
   logic             next_setval;
   logic             next_cupd;
   logic             next_cval;

   // Per-mode result; results other than result_valid and carry_update hold between instructions
   always_comb
   begin
      next_valid = decode_valid;
      next_mode = mode_q;
      next_length = length_q;
      next_ea = ea_q;
      next_used = used_q;
      next_operand = operand_q;
      next_imm = imm_q;
      next_npc = npc_q;
      next_taken = taken_q;
      next_bitnum = bitnum_q;
      next_setval = setval_q;
      next_cupd = 1'b0;
      next_cval = cval_q;
      if (decode_valid)
      begin
         next_mode = decoded_mode;
         next_length = decoded_length;
         next_ea = '0;
         next_used = 1'b0;
         next_operand = 8'h00;
         next_imm = 1'b0;
         next_npc = fall_through;
         next_taken = 1'b0;
         next_bitnum = opcode[ea_pkg::BIT_NUM_MSB:ea_pkg::BIT_NUM_LSB];
         next_setval = 1'b0;
         case (decoded_mode)
            ea_pkg::mode_immediate:
            begin
               next_operand = byte_two;
               next_imm = 1'b1;
            end
            ea_pkg::mode_direct:
            begin
               next_ea = {{(AW-8){1'b0}}, byte_two};
               next_used = 1'b1;
            end
            ea_pkg::mode_extended:
            begin
               next_ea = long_address[AW-1:0];
               next_used = 1'b1;
            end
            ea_pkg::mode_relative:
            begin
               // Branch to subroutine is unconditional
               next_taken = cond_taken || column == ea_pkg::COL_IMMEDIATE;
               if (next_taken)
                  next_npc = branch_target;
            end
            ea_pkg::mode_indexed_0:
            begin
               next_ea = index_wide;
               next_used = 1'b1;
            end
            ea_pkg::mode_indexed_8:
            begin
               next_ea = {{(AW-9){1'b0}}, short_indexed};
               next_used = 1'b1;
            end
            ea_pkg::mode_indexed_16:
            begin
               next_ea = long_indexed[AW-1:0];
               next_used = 1'b1;
            end
            ea_pkg::mode_bit_set_clear:
            begin
               next_ea = {{(AW-8){1'b0}}, byte_two};
               next_used = 1'b1;
               next_setval = !opcode[ea_pkg::SENSE_BIT];
            end
            ea_pkg::mode_bit_test_branch:
            begin
               next_ea = {{(AW-8){1'b0}}, byte_two};
               next_used = 1'b1;
               next_operand = tested_byte;
               next_taken = bit_match;
               if (bit_match)
                  next_npc = branch_target;
               next_cupd = 1'b1;
               next_cval = tested_bit;
            end
            default:
            begin
               next_used = 1'b0;
            end
         endcase
      end
   end

   // Plain register stage; reset clears every result except the length, which loads LEN_ONE
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         mode_q <= ea_pkg::mode_inherent;
         valid_q <= 1'b0;
         length_q <= ea_pkg::LEN_ONE;
         ea_q <= '0;
         used_q <= 1'b0;
         operand_q <= 8'h00;
         imm_q <= 1'b0;
         npc_q <= '0;
         taken_q <= 1'b0;
         bitnum_q <= 3'h0;
         setval_q <= 1'b0;
         cupd_q <= 1'b0;
         cval_q <= 1'b0;
      end
      else
      begin
         mode_q <= next_mode;
         valid_q <= next_valid;
         length_q <= next_length;
         ea_q <= next_ea;
         used_q <= next_used;
         operand_q <= next_operand;
         imm_q <= next_imm;
         npc_q <= next_npc;
         taken_q <= next_taken;
         bitnum_q <= next_bitnum;
         setval_q <= next_setval;
         cupd_q <= next_cupd;
         cval_q <= next_cval;
      end
   end

   // Only the numbered bit is touched by the data path
   assign bit_mask = 8'h01 << bitnum_q;
   assign result_valid = valid_q;
   assign mode = mode_q;
   assign instruction_length = length_q;
   assign effective_address = ea_q;
   assign address_used = used_q;
   assign operand = operand_q;
   assign operand_immediate = imm_q;
   assign next_program_counter = npc_q;
   assign branch_taken = taken_q;
   assign bit_number = bitnum_q;
   assign bit_set_value = setval_q;
   assign carry_update = cupd_q;
   assign carry_value = cval_q;

endmodule

// >>> tb/cpu_effective_address_generator_checker.sv
/*
 Checker for the effective-address generator: answer timing and address
 relations seen at the top ports. Assumes it is bound from the bench top.
*/
`timescale 1ns/10ps
module cpu_effective_address_generator_checker
(
   input wire logic             clk,
   input wire logic             reset_n,
   input wire logic             decode_valid,
   input wire logic [7:0]       opcode,
   input wire logic [7:0]       byte_two,
   input wire logic [7:0]       byte_three,
   input wire logic [7:0]       index_register,
   input wire logic [12:0]      program_counter,
   input wire logic [7:0]       tested_byte,
   input wire logic             result_valid,
   input wire ea_pkg::mode_type mode,
   input wire logic [12:0]      effective_address,
   input wire logic [7:0]       operand,
   input wire logic [12:0]      next_program_counter,
   input wire logic             branch_taken,
   input wire logic             carry_update,
   input wire logic             carry_value
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // A decode taken from one opcode column
   sequence s_col(logic [3:0] c);
      decode_valid && opcode[7:4] == c;
   endsequence

   AST_ANSWER: assert property (decode_valid |=> result_valid)
      else $error("no result one cycle after decode");
   // Idle cycles must neither answer nor disturb the held address
   AST_QUIET: assert property (!decode_valid |=> !result_valid && $stable(effective_address))
      else $error("output moved without a decode");
   AST_EXTENDED: assert property (s_col(4'hc) |=> mode == ea_pkg::mode_extended
      && effective_address == {$past(byte_two[4:0]), $past(byte_three)})
      else $error("extended address wrong");
   AST_DIRECT: assert property (s_col(4'hb) |=> effective_address == {5'h00, $past(byte_two)})
      else $error("direct address wrong");
   AST_INDEX_ZERO: assert property (s_col(4'hf) |=> effective_address == {5'h00, $past(index_register)})
      else $error("indexed address wrong");
   AST_INDEX_BYTE: assert property (s_col(4'he) |=>
      effective_address == 13'($past(index_register)) + 13'($past(byte_two)))
      else $error("indexed byte offset address wrong");
   AST_IMMEDIATE: assert property (s_col(4'ha) ##0 opcode[3:0] != 4'hd |=>
      operand == $past(byte_two))
      else $error("immediate operand wrong");
   AST_ALWAYS: assert property (decode_valid && opcode == 8'h20 |=> branch_taken
      && next_program_counter == $past(program_counter) + 13'h2
      + 13'($signed($past(byte_two))))
      else $error("unconditional branch target wrong");
   AST_NEVER: assert property (decode_valid && opcode == 8'h21 |=>
      !branch_taken && next_program_counter == $past(program_counter) + 13'h2)
      else $error("branch never taken wrongly");
   AST_CARRY: assert property (s_col(4'h0) |=> carry_update
      && carry_value == $past(tested_byte[opcode[3:1]]))
      else $error("tested bit not copied to carry");
endmodule

// >>> tb/cpu_effective_address_generator_tb_top.sv
/*
 Bench for the effective-address generator: corner cases, every opcode
 column, all branch conditions, bit tests, random traffic and a mid-run
 reset, each result compared with an integer model.
 Assumes ea_pkg, the design and the checker are compiled first.
*/
`timescale 1ns/10ps
module cpu_effective_address_generator_tb_top;
   logic             clk;
   logic             reset_n;
   logic             decode_valid;
   logic [7:0]       opcode;
   logic [7:0]       byte_two;
   logic [7:0]       byte_three;
   logic [7:0]       index_register;
   logic [12:0]      program_counter;
   logic [4:0]       condition_flags;
   logic             irq_pin_n;
   logic [7:0]       tested_byte;
   logic             result_valid;
   ea_pkg::mode_type mode;
   logic [1:0]       instruction_length;
   logic [12:0]      effective_address;
   logic             address_used;
   logic [7:0]       operand;
   logic             operand_immediate;
   logic [12:0]      next_program_counter;
   logic             branch_taken;
   logic [2:0]       bit_number;
   logic [7:0]       bit_mask;
   logic             bit_set_value;
   logic             carry_update;
   logic             carry_value;
   logic [15:0]      lf;
   bit               pend;
   int               fail_count;
   int               n_compared;
   int               cyc;
   int               i;
   int               e_rv, e_mode, e_len, e_ea, e_used, e_op, e_imm, e_npc, e_tk;
   int               e_cu, e_cv, e_bn, e_bs;

   cpu_effective_address_generator i_dut (.clk, .reset_n, .decode_valid, .opcode, .byte_two,
      .byte_three, .index_register, .program_counter, .condition_flags, .irq_pin_n,
      .tested_byte, .result_valid, .mode, .instruction_length, .effective_address,
      .address_used, .operand, .operand_immediate, .next_program_counter, .branch_taken,
      .bit_number, .bit_mask, .bit_set_value, .carry_update, .carry_value);

   // 125 MHz clock
   initial
   begin
      clk = 0;
      forever #4 clk = ~clk;
   end

   // Hang guard: the tests need about 2300 cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 8000)
      begin
         fail_count++;
         $display("Error at %0t: timeout", $time);
         final_report();
      end
   end

   function automatic logic [15:0] draw();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return lf;
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic check_all();
      check(16'(result_valid), 16'(e_rv));
      check(16'(mode), 16'(e_mode));
      check(16'(instruction_length), 16'(e_len));
      check(16'(effective_address), 16'(e_ea));
      check(16'(address_used), 16'(e_used));
      check(16'(operand), 16'(e_op));
      check(16'(operand_immediate), 16'(e_imm));
      check(16'(next_program_counter), 16'(e_npc));
      check(16'(branch_taken), 16'(e_tk));
      check(16'(carry_update), 16'(e_cu));
      check(16'(carry_value), 16'(e_cv));
      check(16'(bit_number), 16'(e_bn));
      check(16'(bit_mask), 16'(1 << e_bn));
      check(16'(bit_set_value), 16'(e_bs));
   endtask

   // Integer model of one decode from the values now on the inputs
   task automatic model();
      int   m;
      int   off;
      logic bv;
      logic cnd;
      bv = tested_byte[opcode[3:1]];
      case (opcode[7:4])
         4'h0: m = 9;
         4'h1: m = 8;
         4'h2: m = 4;
         4'h3, 4'hb: m = 2;
         4'h6, 4'he: m = 6;
         4'h7, 4'hf: m = 5;
         4'ha: m = (opcode[3:0] == 4'hd) ? 4 : 1;
         4'hc: m = 3;
         4'hd: m = 7;
         default: m = 0;
      endcase
      // Even selectors test one sense, the odd neighbour the other
      case (opcode[3:1])
         3'h0: cnd = 1;
         3'h1: cnd = !(condition_flags[0] | condition_flags[1]);
         3'h2: cnd = !condition_flags[0];
         3'h3: cnd = !condition_flags[1];
         3'h4: cnd = !condition_flags[4];
         3'h5: cnd = !condition_flags[2];
         3'h6: cnd = !condition_flags[3];
         default: cnd = !irq_pin_n;
      endcase
      cnd = (opcode[7:4] == 4'ha) ? 1'b1 : cnd ^ opcode[0];
      case (m)
         2, 8, 9: e_ea = byte_two;
         3: e_ea = {byte_two, byte_three} & 'h1fff;
         5: e_ea = index_register;
         6: e_ea = index_register + byte_two;
         7: e_ea = ({byte_two, byte_three} + index_register) & 'h1fff;
         default: e_ea = 0;
      endcase
      case (m)
         0, 5: e_len = 1;
         3, 7, 9: e_len = 3;
         default: e_len = 2;
      endcase
      off = (m == 9) ? $signed(byte_three) : $signed(byte_two);
      e_tk = (m == 4) ? cnd : (m == 9) ? (bv ^ opcode[0]) : 0;
      e_npc = (program_counter + e_len + (e_tk ? off : 0)) & 'h1fff;
      e_rv = 1;
      e_mode = m;
      e_used = !(m inside {0, 1, 4});
      e_op = (m == 1) ? byte_two : (m == 9) ? tested_byte : 0;
      e_imm = (m == 1);
      e_cu = (m == 9);
      e_cv = (m == 9) ? bv : e_cv;
      // Every decode reloads the bit fields; only bit set drives a set value
      e_bn = opcode[3:1];
      e_bs = (m == 8) && !opcode[0];
   endtask

   // Checks the previous result, then drives one cycle of inputs
   task automatic step(input logic v, input logic [7:0] op, input logic [7:0] b2,
      input logic [7:0] b3, input logic [7:0] x, input logic [12:0] pc,
      input logic [4:0] fl, input logic [7:0] tb);
      @(posedge clk);
      #1;
      if (pend) check_all();
      decode_valid = v;
      opcode = op;
      byte_two = b2;
      byte_three = b3;
      index_register = x;
      program_counter = pc;
      condition_flags = fl;
      tested_byte = tb;
      e_rv = 0;
      e_cu = 0;
      if (v) model();
      pend = 1;
   endtask

   task automatic rnd_step(input logic v, input logic [7:0] op);
      logic [15:0] a;
      logic [15:0] b;
      logic [15:0] c;
      a = draw();
      b = draw();
      c = draw();
      step(v, op, a[7:0], a[15:8], b[7:0], c[12:0], b[12:8], {c[15:13], b[15:13], a[1:0]});
   endtask

   // The line level is only seen two edges late, so decodes pause meanwhile
   task automatic irq_level(input logic lvl);
      rnd_step(0, 8'h00);
      irq_pin_n = lvl;
      repeat (3) rnd_step(0, 8'h00);
   endtask

   task automatic reset_check();
      e_rv = 0;
      e_mode = 0;
      e_len = 1;
      {e_ea, e_used, e_op, e_imm, e_npc, e_tk, e_cu, e_cv, e_bn, e_bs} = '0;
      check_all();
      pend = 0;
   endtask

   task automatic note(input string s);
      $display("Test %s done, mismatches so far %0d", s, fail_count);
   endtask

   task automatic final_report();
      $display("Compared %0d values, %0d mismatches", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      {reset_n, decode_valid, opcode, byte_two, byte_three, index_register} = '0;
      {program_counter, condition_flags, tested_byte, pend, cyc} = '0;
      irq_pin_n = 1;
      fail_count = 0;
      n_compared = 0;
      lf = 16'h93c9;
      repeat (12) @(posedge clk);
      #1;
      reset_check();
      reset_n = 1;
      note("reset");
      step(1, 8'hc6, 8'h12, 8'h34, 8'h00, 13'h0100, 5'h00, 8'h00);
      step(1, 8'hc6, 8'hff, 8'hff, 8'h00, 13'h0100, 5'h00, 8'h00);
      step(1, 8'hd6, 8'hff, 8'hff, 8'hff, 13'h0100, 5'h00, 8'h00);
      step(1, 8'he6, 8'hff, 8'h00, 8'hff, 13'h0100, 5'h00, 8'h00);
      step(1, 8'hf6, 8'h00, 8'h00, 8'hff, 13'h1fff, 5'h00, 8'h00);
      step(1, 8'hb6, 8'hff, 8'h00, 8'h00, 13'h0000, 5'h00, 8'h00);
      step(1, 8'ha6, 8'h5a, 8'h00, 8'h00, 13'h0100, 5'h00, 8'h00);
      step(1, 8'had, 8'h80, 8'h00, 8'h00, 13'h0010, 5'h00, 8'h00);
      step(1, 8'h20, 8'h7f, 8'h00, 8'h00, 13'h1ffe, 5'h00, 8'h00);
      step(1, 8'h20, 8'hfe, 8'h00, 8'h00, 13'h0200, 5'h00, 8'h00);
      step(1, 8'h21, 8'h80, 8'h00, 8'h00, 13'h0200, 5'h00, 8'h00);
      step(1, 8'h01, 8'h40, 8'h80, 8'h00, 13'h0005, 5'h00, 8'h00);
      step(1, 8'h0e, 8'h40, 8'h7f, 8'h00, 13'h1ffc, 5'h00, 8'h80);
      for (i = 0; i < 16; i++) rnd_step(1, {i[3:0], 4'h6});
      note("corners");
      for (i = 0; i < 128; i++)
      begin
         if (i % 64 == 0) irq_level(i[6]);
         rnd_step(1, {4'h2, i[3:0]});
      end
      note("branches");
      for (i = 0; i < 64; i++) rnd_step(1, {3'h0, i[4:0]});
      note("bits");
      for (i = 0; i < 2000; i++)
      begin
         lf = draw();
         if (i % 256 == 255) irq_level(lf[8]);
         rnd_step(lf[15:13] != 0, lf[7:0]);
      end
      note("random");
      rnd_step(1, 8'h0c);
      rnd_step(0, 8'h00);
      reset_n = 0;
      @(posedge clk);
      #1;
      reset_check();
      reset_n = 1;
      for (i = 0; i < 40; i++) rnd_step(1, 8'(draw()));
      rnd_step(0, 8'h00);
      rnd_step(0, 8'h00);
      note("second reset");
      final_report();
   end
endmodule

bind cpu_effective_address_generator cpu_effective_address_generator_checker i_chk (.clk,
   .reset_n, .decode_valid, .opcode, .byte_two, .byte_three, .index_register,
   .program_counter, .tested_byte, .result_valid, .mode, .effective_address, .operand,
   .next_program_counter, .branch_taken, .carry_update, .carry_value);
